// file: src/dmrb_bank.sv
// Drive monitoring register bank with host read/write port and display select
`timescale 1ns/10ps
`default_nettype none
module dmrb_bank
    import dmrb_pkg::*;
#(
    parameter int GATE_CYC = GATE_CYCLES
) (
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    input  wire dmrb_req_t                host_req,
    output logic [15:0]                   host_rdata,
    output logic                          host_ack,
    output logic                          host_err,
    input  wire logic                     drive_running,
    input  wire logic [4:0]               run_display_select,
    input  wire logic [4:0]               stop_display_select,
    output logic [15:0]                   display_value,
    input  wire logic [1:0]               freq_resolution_select,
    input  wire logic                     ain_two_unit_select,
    input  wire logic                     large_drive,
    input  wire logic [15:0]              loop_scale_setting,
    input  wire logic [15:0]              pulses_per_metre_setting,
    input  wire logic                     timed_run_setting,
    input  wire logic signed [19:0]       theo_freq,
    input  wire logic signed [19:0]       set_freq,
    input  wire logic signed [19:0]       actual_freq,
    input  wire logic signed [19:0]       encoder_freq,
    input  wire logic signed [19:0]       main_freq,
    input  wire logic signed [19:0]       aux_freq,
    input  wire logic [15:0]              bus_voltage,
    input  wire logic [15:0]              out_voltage,
    input  wire logic [19:0]              out_current,
    input  wire logic [15:0]              out_power,
    input  wire logic signed [15:0]       out_torque,
    input  wire logic [DIN_PINS-1:0]      digital_input_pin,
    input  wire logic [VIRT_W-1:0]        virtual_input,
    input  wire dmrb_dout_t               dout_state,
    input  wire logic                     fast_pulse_terminal,
    input  wire logic [AIN_CH-1:0][15:0]  ain_raw,
    input  wire logic [AIN_CH-1:0][15:0]  ain_gain,
    input  wire logic [AIN_CH-1:0][15:0]  ain_offset,
    output logic [AIN_CH-1:0][15:0]       ain_corrected,
    input  wire logic [15:0]              loop_set_pct,
    input  wire logic [15:0]              loop_fb_pct,
    input  wire logic [15:0]              remaining_time,
    input  wire logic [15:0]              load_speed
);

    function automatic logic [15:0] sat_u(input logic [31:0] v,
                                          input logic [15:0] lim);
        sat_u = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction : sat_u

    function automatic logic [15:0] sat_s(input logic signed [31:0] v,
                                          input logic [15:0] lim);
        logic signed [31:0] l;
        l = signed'({16'h0000, lim});
        if (v > l)
            sat_s = lim;
        else if (v < -l)
            sat_s = 16'(-l);
        else
            sat_s = v[15:0];
    endfunction : sat_s

    function automatic logic [15:0] scale_freq(input logic signed [19:0] f,
                                               input logic [1:0] res);
        logic signed [31:0] w;
        w = 32'(f);
        if (res == RES_ONE_DEC)
            w = w / DEC_DIV;
        scale_freq = sat_s(w, LIM_FREQ);
    endfunction : scale_freq

    function automatic logic [19:0] abs20(input logic signed [19:0] f);
        abs20 = f[19] ? 20'(-f) : f;
    endfunction : abs20

    function automatic logic in_mon(input logic [15:0] a);
        in_mon = (a >= DMRB_MON_BASE) && (a <= DMRB_MON_LAST);
    endfunction : in_mon

    function automatic logic [15:0] dout_word(input dmrb_dout_t d);
        dout_word = {6'h00, d.virtual_output, d.digital_output_two,
                     d.digital_output_one, d.relay_two, d.relay_one,
                     d.digital_output_three};
    endfunction : dout_word

    // Input pin synchronisers
    logic [DIN_PINS-1:0] din_s1_r;
    logic [DIN_PINS-1:0] din_s2_r;
    logic                pulse_s1_r;
    logic                pulse_s2_r;
    logic                pulse_s3_r;

    always_ff @(posedge ref_clk) begin
        din_s1_r   <= digital_input_pin;
        din_s2_r   <= din_s1_r;
        pulse_s1_r <= fast_pulse_terminal;
        pulse_s2_r <= pulse_s1_r;
        pulse_s3_r <= pulse_s2_r;
    end

    // Pulse frequency gate counter
    logic [31:0] gate_cnt_r;
    logic [23:0] edge_cnt_r;
    logic [23:0] pulse_hz_r;
    wire         pulse_edge = pulse_s2_r & ~pulse_s3_r;
    wire         gate_done  = (gate_cnt_r == 32'(GATE_CYC - 1));

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gate_cnt_r <= 32'h00000000;
            edge_cnt_r <= 24'h000000;
            pulse_hz_r <= 24'h000000;
        end else begin
            gate_cnt_r <= gate_done ? 32'h00000000 : gate_cnt_r + 32'h00000001;
            if (gate_done) begin
                pulse_hz_r <= edge_cnt_r + 24'(pulse_edge);
                edge_cnt_r <= 24'h000000;
            end else begin
                edge_cnt_r <= edge_cnt_r + 24'(pulse_edge);
            end
        end
    end

    wire [31:0] pulse_hz_w  = 32'(pulse_hz_r);
    wire [31:0] pulse_khz_w = pulse_hz_w / DEC_DIV;
    wire [31:0] pulse_min_w = pulse_hz_w * SEC_PER_MIN;
    wire [31:0] lin_spd_w   = (pulses_per_metre_setting == 16'h0000)
                              ? 32'h00000000
                              : pulse_min_w / {16'h0000, pulses_per_metre_setting};

    // Linear correction of each analog channel
    wire [AIN_CH-1:0][15:0] corr_w;
    genvar ch;
    generate
        for (ch = 0; ch < AIN_CH; ch++) begin : g_corr
            wire signed [31:0] prod = signed'(ain_raw[ch]) * signed'(ain_gain[ch]);
            wire signed [31:0] sum  = (prod >>> CORR_SHIFT)
                                    + 32'(signed'(ain_offset[ch]));
            assign corr_w[ch] = sat_s(sum, LIM_S16);
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst)
            ain_corrected <= '0;
        else
            ain_corrected <= corr_w;
    end

    wire [15:0] ain2_lim = ain_two_unit_select ? LIM_AIN_MA : LIM_AIN_V;
    wire [31:0] ain2_w   = corr_w[1][15] ? 32'h00000000
                           : 32'(corr_w[1]);

    wire [31:0] loop_set_w = (32'(loop_set_pct) * 32'(loop_scale_setting)) / PCT_DIV;
    wire [31:0] loop_fb_w  = (32'(loop_fb_pct) * 32'(loop_scale_setting)) / PCT_DIV;
    wire [31:0] cur_w      = large_drive ? 32'(out_current) / DEC_DIV
                                         : 32'(out_current);

    // Host mirror of the communication setting
    logic [15:0] comm_r;
    wire         comm_wr = host_req.wr && (host_req.addr == DMRB_COMM_ADDR);
    wire [15:0]  comm_nxt = sat_s(32'(signed'(host_req.wdata)), LIM_COMM);

    always_ff @(posedge ref_clk) begin
        if (srst)
            comm_r <= 16'h0000;
        else if (comm_wr)
            comm_r <= comm_nxt;
    end

    // Monitoring entries
    logic [15:0] mon_nxt [DMRB_ENTRIES];
    logic [15:0] mon_r   [DMRB_ENTRIES];

    always_comb begin
        for (int i = 0; i < DMRB_ENTRIES; i++)
            mon_nxt[i] = 16'h0000;
        mon_nxt[IDX_RUN_FREQ]  = scale_freq(signed'(abs20(theo_freq)),
                                            freq_resolution_select);
        mon_nxt[IDX_SET_FREQ]  = scale_freq(signed'(abs20(set_freq)),
                                            freq_resolution_select);
        mon_nxt[IDX_BUS_V]     = sat_u(32'(bus_voltage), LIM_BUS_V);
        mon_nxt[IDX_OUT_V]     = sat_u(32'(out_voltage), LIM_OUT_V);
        mon_nxt[IDX_OUT_I]     = sat_u(cur_w, LIM_U16);
        mon_nxt[IDX_OUT_P]     = sat_u(32'(out_power), LIM_POWER);
        mon_nxt[IDX_TORQUE]    = sat_s(32'(out_torque), LIM_TORQUE);
        mon_nxt[IDX_DIN]       = {1'b0, virtual_input, din_s2_r};
        mon_nxt[IDX_DOUT]      = dout_word(dout_state);
        mon_nxt[IDX_AIN2]      = sat_u(ain2_w, ain2_lim);
        mon_nxt[IDX_LOAD_SPD]  = load_speed;
        mon_nxt[IDX_LOOP_SET]  = sat_u(loop_set_w, LIM_U16);
        mon_nxt[IDX_LOOP_FB]   = sat_u(loop_fb_w, LIM_U16);
        mon_nxt[IDX_PULSE_KHZ] = sat_u(pulse_khz_w, LIM_PULSE_KHZ);
        mon_nxt[IDX_ACT_FREQ]  = scale_freq(actual_freq,
                                            freq_resolution_select);
        mon_nxt[IDX_RUN_TIME]  = timed_run_setting
                                 ? sat_u(32'(remaining_time), LIM_RUN_TIME)
                                 : 16'h0000;
        mon_nxt[IDX_AIN1_RAW]  = ain_raw[0];
        mon_nxt[IDX_AIN2_RAW]  = ain_raw[1];
        mon_nxt[IDX_AIN3_RAW]  = ain_raw[2];
        mon_nxt[IDX_LIN_SPD]   = sat_u(lin_spd_w, LIM_U16);
        mon_nxt[IDX_PULSE_HZ]  = sat_u(pulse_hz_w, LIM_U16);
        mon_nxt[IDX_COMM]      = comm_r;
        mon_nxt[IDX_ENC_FREQ]  = scale_freq(encoder_freq,
                                            freq_resolution_select);
        mon_nxt[IDX_MAIN_FREQ] = scale_freq(main_freq,
                                            freq_resolution_select);
        mon_nxt[IDX_AUX_FREQ]  = scale_freq(aux_freq,
                                            freq_resolution_select);
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < DMRB_ENTRIES; i++)
            mon_r[i] <= srst ? 16'h0000 : mon_nxt[i];
    end

    // Host access decode
    wire [15:0] rel_addr = host_req.addr - DMRB_MON_BASE;
    wire        rd_mon   = host_req.rd && in_mon(host_req.addr);
    wire        rd_comm  = host_req.rd && (host_req.addr == DMRB_COMM_ADDR);
    wire        wr_mon   = host_req.wr && in_mon(host_req.addr);
    wire        hit_low  = (rel_addr < 16'(DMRB_ENTRIES));
    wire [15:0] mon_sel  = hit_low ? mon_r[rel_addr[DMRB_IDX_W-1:0]] : 16'h0000;
    wire        req_ok   = rd_mon || rd_comm || wr_mon || comm_wr;
    wire        req_any  = host_req.rd || host_req.wr;
    wire [15:0] rdata_nxt = rd_comm ? comm_r : (rd_mon ? mon_sel : 16'h0000);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            host_rdata <= 16'h0000;
            host_ack   <= 1'b0;
            host_err   <= 1'b0;
        end else begin
            host_rdata <= rdata_nxt;
            host_ack   <= req_any && req_ok;
            host_err   <= req_any && !req_ok;
        end
    end

    // Panel display selection
    wire [4:0]  disp_idx = drive_running ? run_display_select
                                         : stop_display_select;
    wire [15:0] disp_nxt = mon_r[disp_idx];

    always_ff @(posedge ref_clk) begin
        if (srst)
            display_value <= 16'h0000;
        else
            display_value <= disp_nxt;
    end

    chk_mon_read: assert property (@(posedge ref_clk) disable iff (srst)
        host_req.rd && host_req.addr == DMRB_MON_BASE
        |=> host_ack && !host_err && host_rdata == $past(mon_r[0]))
        else $error("monitor read did not answer");

    chk_write_ignored: assert property (@(posedge ref_clk) disable iff (srst)
        wr_mon |=> host_ack && $stable(comm_r))
        else $error("monitor write not ignored");

    chk_comm_mirror: assert property (@(posedge ref_clk) disable iff (srst)
        comm_wr |=> comm_r == $past(comm_nxt) ##1 mon_r[IDX_COMM] == $past(comm_r))
        else $error("communication mirror wrong");

    chk_display_sel: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> display_value == $past(disp_nxt))
        else $error("display selection wrong");

    chk_bus_limit: assert property (@(posedge ref_clk) disable iff (srst)
        mon_r[IDX_BUS_V] <= LIM_BUS_V)
        else $error("bus voltage above limit");

    chk_din_pack: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(srst) |-> mon_r[IDX_DIN][15] == 1'b0
        && mon_r[IDX_DIN][14:10] == $past(virtual_input))
        else $error("input word packing wrong");

    chk_dout_pack: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(srst) |-> mon_r[IDX_DOUT] == dout_word($past(dout_state)))
        else $error("output word packing wrong");

    chk_rd_idle: assert property (@(posedge ref_clk) disable iff (srst)
        !host_req.rd |=> host_rdata == 16'h0000)
        else $error("read data not cleared");

    chk_err_map: assert property (@(posedge ref_clk) disable iff (srst)
        host_req.rd && !in_mon(host_req.addr)
        && host_req.addr != DMRB_COMM_ADDR |=> host_err && !host_ack)
        else $error("unmapped read not refused");

    chk_torq_lim: assert property (@(posedge ref_clk) disable iff (srst)
        $signed(mon_r[IDX_TORQUE]) <= $signed(LIM_TORQUE)
        && $signed(mon_r[IDX_TORQUE]) >= -$signed(LIM_TORQUE))
        else $error("torque above limit");

    chk_raw_copy: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(srst) |-> mon_r[IDX_AIN3_RAW] == $past(ain_raw[2]))
        else $error("raw analog sample not exposed");

    chk_freq_abs: assert property (@(posedge ref_clk) disable iff (srst)
        !mon_r[IDX_RUN_FREQ][15] && !mon_r[IDX_SET_FREQ][15])
        else $error("frequency shown with sign");

    chk_ain_unit: assert property (@(posedge ref_clk) disable iff (srst)
        ain_two_unit_select ##1 ain_two_unit_select
        |-> mon_r[IDX_AIN2] <= LIM_AIN_MA)
        else $error("analog two above limit");

    chk_run_time: assert property (@(posedge ref_clk) disable iff (srst)
        !timed_run_setting |=> mon_r[IDX_RUN_TIME] == 16'h0000)
        else $error("remaining time shown while disabled");

    chk_pulse_khz: assert property (@(posedge ref_clk) disable iff (srst)
        mon_r[IDX_PULSE_KHZ] <= LIM_PULSE_KHZ)
        else $error("pulse frequency above limit");

endmodule : dmrb_bank
`default_nettype wire

// file: src/dmrb_pkg.sv
// Constants and carrier types for the drive monitoring register bank
package dmrb_pkg;
    localparam logic [15:0] DMRB_MON_BASE     = 16'h7000;
    localparam logic [15:0] DMRB_MON_LAST     = 16'h7044;
    localparam logic [15:0] DMRB_COMM_ADDR    = 16'h1000;
    localparam int          DMRB_ENTRIES      = 32;
    localparam int          DMRB_IDX_W        = 5;
    // Entry indices, offset from the base address
    localparam logic [4:0]  IDX_RUN_FREQ      = 5'h00;
    localparam logic [4:0]  IDX_SET_FREQ      = 5'h01;
    localparam logic [4:0]  IDX_BUS_V         = 5'h02;
    localparam logic [4:0]  IDX_OUT_V         = 5'h03;
    localparam logic [4:0]  IDX_OUT_I         = 5'h04;
    localparam logic [4:0]  IDX_OUT_P         = 5'h05;
    localparam logic [4:0]  IDX_TORQUE        = 5'h06;
    localparam logic [4:0]  IDX_DIN           = 5'h07;
    localparam logic [4:0]  IDX_DOUT          = 5'h08;
    localparam logic [4:0]  IDX_AIN2          = 5'h0A;
    localparam logic [4:0]  IDX_LOAD_SPD      = 5'h0E;
    localparam logic [4:0]  IDX_LOOP_SET      = 5'h0F;
    localparam logic [4:0]  IDX_LOOP_FB       = 5'h10;
    localparam logic [4:0]  IDX_PULSE_KHZ     = 5'h12;
    localparam logic [4:0]  IDX_ACT_FREQ      = 5'h13;
    localparam logic [4:0]  IDX_RUN_TIME      = 5'h14;
    localparam logic [4:0]  IDX_AIN1_RAW      = 5'h15;
    localparam logic [4:0]  IDX_AIN2_RAW      = 5'h16;
    localparam logic [4:0]  IDX_AIN3_RAW      = 5'h17;
    localparam logic [4:0]  IDX_LIN_SPD       = 5'h18;
    localparam logic [4:0]  IDX_PULSE_HZ      = 5'h1B;
    localparam logic [4:0]  IDX_COMM          = 5'h1C;
    localparam logic [4:0]  IDX_ENC_FREQ      = 5'h1D;
    localparam logic [4:0]  IDX_MAIN_FREQ     = 5'h1E;
    localparam logic [4:0]  IDX_AUX_FREQ      = 5'h1F;
    // Display limits in the entry's own units, then scale factors, shifts and widths
    localparam logic [15:0] LIM_BUS_V         = 16'h7530;
    localparam logic [15:0] LIM_OUT_V         = 16'h0474;
    localparam logic [15:0] LIM_POWER         = 16'h7FFF;
    localparam logic [15:0] LIM_TORQUE        = 16'h07D0;
    localparam logic [15:0] LIM_AIN_V         = 16'h0421;
    localparam logic [15:0] LIM_AIN_MA        = 16'h07D0;
    localparam logic [15:0] LIM_PULSE_KHZ     = 16'h2710;
    localparam logic [15:0] LIM_FREQ          = 16'h7D00;
    localparam logic [15:0] LIM_RUN_TIME      = 16'hFDE8;
    localparam logic [15:0] LIM_COMM          = 16'h2710;
    localparam logic [15:0] LIM_U16           = 16'hFFFF;
    localparam logic [15:0] LIM_S16           = 16'h7FFF;
    localparam logic [1:0]  RES_ONE_DEC       = 2'h1;
    localparam logic [1:0]  RES_TWO_DEC       = 2'h2;
    localparam int          DEC_DIV           = 10;
    localparam int          PCT_DIV           = 10000;
    localparam int          SEC_PER_MIN       = 60;
    localparam int          CORR_SHIFT        = 12;
    localparam int          DIN_PINS          = 10;
    localparam int          VIRT_W            = 5;
    localparam int          AIN_CH            = 3;
    // Pulse frequency gate time and its cycle count
    localparam int          CLK_HZ            = 125000000;
    localparam int          GATE_TIME_MS      = 1000;
    localparam int          MS_PER_S          = 1000;
    localparam int          GATE_CYCLES       = CLK_HZ / MS_PER_S * GATE_TIME_MS;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dmrb_req_t;

    typedef struct packed {
        logic       digital_output_three;
        logic       relay_one;
        logic       relay_two;
        logic       digital_output_one;
        logic       digital_output_two;
        logic [4:0] virtual_output;
    } dmrb_dout_t;
endpackage : dmrb_pkg

// file: sim/dmrb_host_model.sv
// Host computer model driving the monitoring bank request port
`timescale 1ns/10ps
`default_nettype none
module dmrb_host_model
    import dmrb_pkg::*;
(
    input  wire logic        ref_clk,
    output var  dmrb_req_t   host_req,
    input  wire logic [15:0] host_rdata,
    input  wire logic        host_ack,
    input  wire logic        host_err
);
    initial host_req = '0;
    // One strobe cycle, answer taken in the following cycle
    task automatic xfer(input logic wr, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic [1:0] ae);
        @(posedge ref_clk);
        host_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge ref_clk);
        // Released strobes go low; address and data lines show the inverse of the last value
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        @(posedge ref_clk);
        q  = host_rdata;
        ae = {host_ack, host_err};
    endtask : xfer
endmodule : dmrb_host_model
`default_nettype wire

// file: sim/dmrb_bank_tb.sv
// Self-checking bench for the drive monitoring register bank
`timescale 1ns/10ps
`default_nettype none
module dmrb_bank_tb;
    import dmrb_pkg::*;
    localparam int GATE = 1000;
    localparam int HZ   = GATE / 4;
    logic ref_clk = 1'b0, srst = 1'b1, drive_running = 1'b0;
    dmrb_req_t host_req;
    logic [15:0] host_rdata, display_value;
    logic host_ack, host_err, ain_two_unit_select = 1'b0;
    logic large_drive = 1'b0, timed_run_setting = 1'b0;
    logic fast_pulse_terminal = 1'b0;
    logic [4:0] run_display_select = '0, stop_display_select = '0;
    logic [1:0] freq_resolution_select = 2'h2, pcnt = 2'h0;
    logic [15:0] loop_scale_setting = '0, pulses_per_metre_setting = '0;
    logic signed [19:0] theo_freq = '0, set_freq = '0, actual_freq = '0;
    logic signed [19:0] encoder_freq = '0, main_freq = '0, aux_freq = '0;
    logic [15:0] bus_voltage = '0, out_voltage = '0, out_power = '0;
    logic [19:0] out_current = '0;
    logic signed [15:0] out_torque = '0;
    logic [9:0] digital_input_pin = '0;
    logic [4:0] virtual_input = '0;
    dmrb_dout_t dout_state = '0;
    logic [2:0][15:0] ain_raw = '0, ain_gain = '0, ain_offset = '0;
    logic [2:0][15:0] ain_corrected;
    logic [15:0] loop_set_pct = '0, loop_fb_pct = '0;
    logic [15:0] remaining_time = '0, load_speed = '0, mirror = '0;
    int err_count = 0, total_checks = 0;

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        pcnt <= pcnt + 2'h1;
        fast_pulse_terminal <= pcnt[1];
    end

    dmrb_bank #(.GATE_CYC(GATE)) dut (.ref_clk, .srst, .host_req,
        .host_rdata, .host_ack, .host_err, .drive_running,
        .run_display_select, .stop_display_select, .display_value,
        .freq_resolution_select, .ain_two_unit_select, .large_drive,
        .loop_scale_setting, .pulses_per_metre_setting,
        .timed_run_setting, .theo_freq, .set_freq, .actual_freq,
        .encoder_freq, .main_freq, .aux_freq, .bus_voltage, .out_voltage,
        .out_current, .out_power, .out_torque, .digital_input_pin,
        .virtual_input, .dout_state, .fast_pulse_terminal, .ain_raw,
        .ain_gain, .ain_offset, .ain_corrected, .loop_set_pct,
        .loop_fb_pct, .remaining_time, .load_speed);
    dmrb_host_model host (.ref_clk, .host_req, .host_rdata, .host_ack,
        .host_err);

    function automatic logic [15:0] cl(longint v, longint lo, longint hi);
        longint r;
        r = (v < lo) ? lo : (v > hi) ? hi : v;
        return r[15:0];
    endfunction : cl
    function automatic longint frq(logic signed [19:0] f, bit ab);
        longint v;
        v = f;
        if (ab && v < 0) v = -v;
        if (freq_resolution_select == 2'h1) v = v / 10;
        return v;
    endfunction : frq
    function automatic longint corr(int k);
        longint v;
        v = (longint'($signed(ain_raw[k])) * $signed(ain_gain[k])) >>> 12;
        v = v + $signed(ain_offset[k]);
        return (v > 32767) ? 32767 : (v < -32767) ? -32767 : v;
    endfunction : corr
    function automatic logic [15:0] exp_entry(int i);
        case (i)
            0: return cl(frq(theo_freq, 1), 0, 32000);
            1: return cl(frq(set_freq, 1), 0, 32000);
            2: return cl(bus_voltage, 0, 30000);
            3: return cl(out_voltage, 0, 1140);
            4: return cl(large_drive ? out_current / 10 : out_current, 0, 65535);
            5: return cl(out_power, 0, 32767);
            6: return cl(out_torque, -2000, 2000);
            7: return {1'b0, virtual_input, digital_input_pin};
            8: return {6'h00, dout_state.virtual_output,
                       dout_state.digital_output_two,
                       dout_state.digital_output_one, dout_state.relay_two,
                       dout_state.relay_one, dout_state.digital_output_three};
            10: return cl(corr(1), 0, ain_two_unit_select ? 2000 : 1057);
            14: return load_speed;
            15: return cl(longint'(loop_set_pct) * loop_scale_setting / 10000,
                          0, 65535);
            16: return cl(longint'(loop_fb_pct) * loop_scale_setting / 10000,
                          0, 65535);
            18: return cl(HZ / 10, 0, 10000);
            19: return cl(frq(actual_freq, 0), -32000, 32000);
            20: return timed_run_setting ? cl(remaining_time, 0, 65000) : 16'h0000;
            21, 22, 23: return ain_raw[i-21];
            24: return (pulses_per_metre_setting == 16'h0000) ? 16'h0000 :
                    cl(HZ * 60 / pulses_per_metre_setting, 0, 65535);
            27: return HZ[15:0];
            28: return mirror;
            29: return cl(frq(encoder_freq, 0), -32000, 32000);
            30: return cl(frq(main_freq, 0), -32000, 32000);
            31: return cl(frq(aux_freq, 0), -32000, 32000);
            default: return 16'h0000;
        endcase
    endfunction : exp_entry
    function automatic logic signed [19:0] rf();
        int v;
        v = int'($urandom_range(800000)) - 400000;
        return v[19:0];
    endfunction : rf

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] want, input logic [1:0] wae);
        logic [15:0] q;
        logic [1:0]  ae;
        host.xfer(wr, a, d, q, ae);
        check({14'h0000, ae}, {14'h0000, wae});
        if (!wr && wae == 2'b10) check(q, want);
    endtask : acc
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic shake(input int n);
        @(posedge ref_clk);
        freq_resolution_select <= 2'(n);
        large_drive <= n[0];
        ain_two_unit_select <= n[1];
        timed_run_setting <= n[0] ^ n[1];
        {theo_freq, set_freq, actual_freq} <= {rf(), rf(), rf()};
        {encoder_freq, main_freq, aux_freq} <= {rf(), rf(), rf()};
        bus_voltage <= 16'($urandom_range(32000));
        out_voltage <= 16'($urandom_range(1300));
        out_current <= 20'($urandom_range(700000));
        out_power <= 16'($urandom);
        out_torque <= 16'(int'($urandom_range(5000)) - 2500);
        {digital_input_pin, virtual_input} <= 15'($urandom);
        dout_state <= 10'($urandom);
        for (int k = 0; k < 3; k++) begin
            ain_raw[k] <= 16'(int'($urandom_range(2000)) - (k == 2 ? 1000 : 0));
            ain_gain[k] <= 16'($urandom_range(16'h1800, 16'h0800));
            ain_offset[k] <= 16'(int'($urandom_range(400)) - 200);
        end
        {loop_set_pct, loop_fb_pct} <= {16'($urandom_range(10000)),
                                       16'($urandom_range(10000))};
        loop_scale_setting <= 16'($urandom);
        pulses_per_metre_setting <= n == 0 ? 16'h0000 : 16'($urandom_range(100));
        {remaining_time, load_speed} <= $urandom;
        repeat (5) @(posedge ref_clk);
    endtask : shake

    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
    initial begin
        logic [15:0] w;
        void'($urandom(32'hE1971766));
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        acc(0, 16'h701C, 16'h0000, 16'h0000, 2'b10);
        repeat (2100) @(posedge ref_clk);
        $display("test reset done");
        for (int n = 0; n < 6; n++) begin
            shake(n);
            for (int i = 0; i < 69; i++) begin
                acc(0, 16'h7000 + 16'(i), 16'h0000, exp_entry(i), 2'b10);
            end
            for (int k = 0; k < 3; k++) check(ain_corrected[k], cl(corr(k), -32767, 32767));
        end
        $display("test entry reads done");
        for (int i = 0; i < 32; i++) begin
            @(posedge ref_clk);
            run_display_select <= 5'(i);
            stop_display_select <= 5'(31 - i);
            drive_running <= i[0];
            repeat (3) @(negedge ref_clk);
            check(display_value, exp_entry(i[0] ? i : 31 - i));
        end
        $display("test display select done");
        acc(1, 16'h7002, 16'hFFFF, 16'h0000, 2'b10);
        acc(0, 16'h7002, 16'h0000, exp_entry(2), 2'b10);
        for (int j = 0; j < 3; j++) begin
            w = (j == 0) ? 16'h7FFF : (j == 1) ? 16'h8000 : 16'h1388;
            mirror = $signed(w) > 10000 ? 16'h2710 :
                     $signed(w) < -10000 ? 16'hD8F0 : w;
            acc(1, 16'h1000, w, 16'h0000, 2'b10);
            acc(0, 16'h701C, 16'h0000, mirror, 2'b10);
            acc(0, 16'h1000, 16'h0000, mirror, 2'b10);
        end
        $display("test comm mirror done");
        acc(0, 16'h7045, 16'h0000, 16'h0000, 2'b01);
        acc(0, 16'h6FFF, 16'h0000, 16'h0000, 2'b01);
        acc(1, 16'h0FFF, 16'h1234, 16'h0000, 2'b01);
        acc(0, 16'h7044, 16'h0000, 16'h0000, 2'b10);
        $display("test address decode done");
        end_sim();
    end
endmodule : dmrb_bank_tb
`default_nettype wire
